//--- pkg/pced_defines.svh
`ifndef PCED_DEFINES_SVH
`define PCED_DEFINES_SVH

// Register byte offsets on the bus.
`define PCED_PORTC_RISE_OFS 12'h000
`define PCED_PORTC_FALL_OFS 12'h004
`define PCED_PORTC_FLAG_OFS 12'h008
`define PCED_PORTE_RISE_OFS 12'h00C
`define PCED_PORTE_FALL_OFS 12'h010
`define PCED_PORTE_FLAG_OFS 12'h014
`define PCED_INTCTL_OFS 12'h018

// Field positions.
`define PCED_PORTE_BIT 3
`define PCED_ANY_FLAG_BIT 0
`define PCED_ANY_IE_BIT 3

// Reset values.
`define PCED_REG_RESET 8'h00

`endif

//--- pkg/pced_pkg.sv
package pced_pkg;

  // Address phase captured from the bus.
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
  } pced_addr_t;

  // Enabled edge hits of both ports in one cycle, after synchronisation.
  typedef struct packed {
    logic [7:0] portc;
    logic       porte;
  } pced_pins_t;

  typedef enum logic [1:0] {
    PCED_IDLE = 2'b01,
    PCED_DATA = 2'b10
  } pced_state_t;

endpackage

//--- src/pced_edge.sv
`timescale 1ns/1ps
`include "pced_defines.svh"

// Synchronises pins and reports enabled edges as one-cycle pulses.
module pced_edge import pced_pkg::*; #(
  parameter int W = 8
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic [W-1:0] pin, // Raw pin levels from outside.
  input wire logic [W-1:0] rise_en, // Rising edge enables.
  input wire logic [W-1:0] fall_en, // Falling edge enables.
  output logic [W-1:0] hit // Enabled edge seen this cycle.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin; // RULE13
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // A disabled direction contributes nothing.
  assign hit = (rise_en & sync_q & ~prev_q) | (fall_en & ~sync_q & prev_q); // RULE8

endmodule // pced_edge

//--- src/pced_top.sv
// Notes on behaviour
// RULE1: Enabled rising edge on port C pin sets flag.
// RULE2: Enabled falling edge on port C pin sets flag.
// RULE3: Port C flag register holds eight flags.
// RULE4: Port E rising edge sets bit three flag.
// RULE5: Port E falling edge sets bit three flag.
// RULE6: Port E rising edge also sets summary flag.
// RULE7: Port E falling edge also sets summary flag.
// RULE8: Disabled edge direction never touches its flag.
// RULE9: Flags stay set until software writes zero.
// RULE10: Port E registers implement only bit three.
// RULE11: All enables and flags reset to zero.
// RULE12: Summary flag bit 0, its enable bit 3.
// RULE13: Pins synchronised; summary is OR of flags.
// RULE14: Hardware set beats simultaneous software clear.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "pced_defines.svh"

module pced_top import pced_pkg::*; (
  input wire logic hclk, // System clock, 10 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [11:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready in.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  input wire logic [7:0] portc_pin, // Port C pins.
  input wire logic porte_pin, // Port E implemented pin.
  output logic any_change_flag, // Summary change flag.
  output logic any_change_irq_enable // Summary flag enable.
);

  pced_state_t state_q;
  pced_state_t state_d;
  pced_addr_t aph_q;
  pced_pins_t hit_s;
  logic [7:0] portc_rise_enable_q;
  logic [7:0] portc_fall_enable_q;
  logic [7:0] portc_change_flags_q;
  logic [7:0] portc_change_flags_d;
  logic porte_rise_enable_q;
  logic porte_fall_enable_q;
  logic porte_change_flag_q;
  logic porte_change_flag_d;
  logic [7:0] porte_flag_full;
  logic irq_enable_q;
  logic any_flag_q;
  logic any_flag_d;
  logic [7:0] portc_hit;
  logic [0:0] porte_hit;
  logic [31:0] rdata_d;
  logic addr_take;
  logic rd_take;
  logic wr_en;
  logic [7:0] wbyte;
  logic wr_portc_rise;
  logic wr_portc_fall;
  logic wr_portc_flag;
  logic wr_porte_rise;
  logic wr_porte_fall;
  logic wr_porte_flag;
  logic wr_intctl;

  // Flags: set by hits, a written 0 clears, a written 1 changes nothing.
  // The hit is merged last, so an edge that lands in the same cycle as a
  // clearing write still leaves its flag set and no event is lost.
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] hit,
                                           input logic wr, input logic [7:0] wd);
    logic [7:0] kept;
    kept = wr ? (cur & wd) : cur; // RULE9
    return kept | hit; // RULE14
  endfunction

  // Places an eight-bit register image in the low byte of a bus word.
  function automatic logic [31:0] widen(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // Places the single implemented port E bit at its place in the byte.
  // The other seven bits are not stored at all, so they can only read 0.
  function automatic logic [7:0] porte_byte(input logic b);
    return {4'h0, b, 3'h0}; // RULE10
  endfunction

  // True when a captured address selects the register at the given offset.
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  pced_edge #(.W(8)) u_portc (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(portc_pin),
    .rise_en(portc_rise_enable_q),
    .fall_en(portc_fall_enable_q),
    .hit(portc_hit)
  );

  pced_edge #(.W(1)) u_porte (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(porte_pin),
    .rise_en(porte_rise_enable_q),
    .fall_en(porte_fall_enable_q),
    .hit(porte_hit)
  );

  // Both ports' enabled edges of this cycle, carried together.
  assign hit_s = '{portc: portc_hit, porte: porte_hit[0]};

  // An address phase is taken only while the bus is ready. The transfer size
  // is not looked at, because every register is one byte wide, in the low byte of its word.
  assign addr_take = hsel && hready && htrans[1];
  assign rd_take = addr_take && !hwrite;

  // Writes complete in the data phase; the slave never stretches.
  assign wr_en = (state_q == PCED_DATA) && aph_q.write;
  assign wbyte = hwdata[7:0];

  // One strobe per register; an unmapped address raises none of them.
  assign wr_portc_rise = wr_en && reg_hit(aph_q.addr, `PCED_PORTC_RISE_OFS);
  assign wr_portc_fall = wr_en && reg_hit(aph_q.addr, `PCED_PORTC_FALL_OFS);
  assign wr_portc_flag = wr_en && reg_hit(aph_q.addr, `PCED_PORTC_FLAG_OFS);
  assign wr_porte_rise = wr_en && reg_hit(aph_q.addr, `PCED_PORTE_RISE_OFS);
  assign wr_porte_fall = wr_en && reg_hit(aph_q.addr, `PCED_PORTE_FALL_OFS);
  assign wr_porte_flag = wr_en && reg_hit(aph_q.addr, `PCED_PORTE_FLAG_OFS);
  assign wr_intctl = wr_en && reg_hit(aph_q.addr, `PCED_INTCTL_OFS);

  // Bus phase tracking. Back-to-back transfers stay in the data state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PCED_IDLE: begin
        if (addr_take) begin
          state_d = PCED_DATA;
        end
      end
      PCED_DATA: begin
        if (!addr_take) begin
          state_d = PCED_IDLE;
        end
      end
      default: begin
        state_d = PCED_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= PCED_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The address phase is held for the data phase that follows it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (addr_take) begin
      aph_q <= '{write: hwrite, addr: haddr};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portc_rise_enable_q <= `PCED_REG_RESET; // RULE11
    end else if (wr_portc_rise) begin
      portc_rise_enable_q <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portc_fall_enable_q <= `PCED_REG_RESET; // RULE11
    end else if (wr_portc_fall) begin
      portc_fall_enable_q <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      porte_rise_enable_q <= 1'h0; // RULE11
    end else if (wr_porte_rise) begin
      porte_rise_enable_q <= wbyte[`PCED_PORTE_BIT]; // RULE10
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      porte_fall_enable_q <= 1'h0; // RULE11
    end else if (wr_porte_fall) begin
      porte_fall_enable_q <= wbyte[`PCED_PORTE_BIT]; // RULE10
    end
  end

  // Only the enable bit is stored; the summary bit of this register is
  // derived from the pin flags, so writes to it are ignored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_q <= 1'h0; // RULE11
    end else if (wr_intctl) begin
      irq_enable_q <= wbyte[`PCED_ANY_IE_BIT]; // RULE12
    end
  end

  // Next flag values, shared by the flag registers and by the summary.
  assign portc_change_flags_d = flag_next(portc_change_flags_q, hit_s.portc, // RULE1 RULE2 RULE3
                                          wr_portc_flag, wbyte);
  assign porte_flag_full = flag_next({7'h00, porte_change_flag_q}, // RULE4 RULE5
                                     {7'h00, hit_s.porte}, wr_porte_flag,
                                     {7'h00, wbyte[`PCED_PORTE_BIT]});
  assign porte_change_flag_d = porte_flag_full[0];

  // The summary is the OR of the next per-pin flags, so it rises in the same
  // cycle as the flag that caused it and falls once the last flag is cleared.
  assign any_flag_d = (|portc_change_flags_d) | porte_change_flag_d; // RULE6 RULE7 RULE13

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portc_change_flags_q <= `PCED_REG_RESET; // RULE11
    end else begin
      portc_change_flags_q <= portc_change_flags_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      porte_change_flag_q <= 1'h0; // RULE11
    end else begin
      porte_change_flag_q <= porte_change_flag_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_flag_q <= 1'h0;
    end else begin
      any_flag_q <= any_flag_d; // RULE12
    end
  end

  // Read data is chosen in the address phase and registered, so it stands
  // for exactly the data phase and is zero in every other cycle.
  always_comb begin
    rdata_d = 32'h00000000;
    if (rd_take) begin
      case (haddr)
        `PCED_PORTC_RISE_OFS: rdata_d = widen(portc_rise_enable_q);
        `PCED_PORTC_FALL_OFS: rdata_d = widen(portc_fall_enable_q);
        `PCED_PORTC_FLAG_OFS: rdata_d = widen(portc_change_flags_q);
        `PCED_PORTE_RISE_OFS: rdata_d = widen(porte_byte(porte_rise_enable_q)); // RULE10
        `PCED_PORTE_FALL_OFS: rdata_d = widen(porte_byte(porte_fall_enable_q));
        `PCED_PORTE_FLAG_OFS: rdata_d = widen(porte_byte(porte_change_flag_q));
        `PCED_INTCTL_OFS: rdata_d = widen({4'h0, irq_enable_q, 2'h0, any_flag_q}); // RULE12
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= rdata_d;
    end
  end

  // The slave never inserts wait states and never signals an error.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
  end

  // The summary pin lags the register image by one cycle, because every
  // output comes straight from its own flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_change_flag <= 1'h0;
    end else begin
      any_change_flag <= any_flag_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_change_irq_enable <= 1'h0;
    end else begin
      any_change_irq_enable <= irq_enable_q;
    end
  end

endmodule // pced_top

//--- tb/pced_chk.sv
`timescale 1ns/1ps
module pced_chk (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hsel, // Select.
  input wire logic [11:0] haddr, // Address.
  input wire logic [1:0] htrans, // Type.
  input wire logic hwrite, // Write.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic hreadyout, // Ready.
  input wire logic hresp, // Response.
  input wire logic [7:0] portc_pin, // Pins.
  input wire logic porte_pin, // Pin.
  input wire logic any_change_flag, // Summary.
  input wire logic any_change_irq_enable // Enable.
);
  logic [8:0] pins_q;
  logic [3:0] pin_age_q;
  logic [3:0] wr_age_q;
  wire rd_go = hsel && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Ages saturate so a long quiet spell never wraps back into the window.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q <= 9'h000;
      pin_age_q <= 4'hF;
      wr_age_q <= 4'hF;
    end else begin
      pins_q <= {portc_pin, porte_pin};
      pin_age_q <= ({portc_pin, porte_pin} != pins_q) ? 4'h0 :
        pin_age_q + {3'h0, pin_age_q != 4'hF};
      wr_age_q <= (hsel && htrans[1] && hwrite) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
    end
  end
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  idle_read_a: assert property (!$past(rd_go) |-> hrdata == 32'h0)
    else $error("hrdata outside read");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  porte_bits_a: assert property ($past(rd_go && haddr >= 12'h00C && haddr <= 12'h014) |->
    hrdata[7:4] == 4'h0 && hrdata[2:0] == 3'h0)
    else $error("port e spare bits set");
  flag_cause_a: assert property ($rose(any_change_flag) |-> pin_age_q < 4'h8)
    else $error("flag rose without pin change");
  flag_clear_a: assert property ($fell(any_change_flag) |-> wr_age_q < 4'h4)
    else $error("flag fell without write");
  ie_write_a: assert property ($changed(any_change_irq_enable) |-> wr_age_q < 4'h4)
    else $error("enable moved without write");
endmodule // pced_chk

bind pced_top pced_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hrdata,
  .hreadyout, .hresp, .portc_pin, .porte_pin, .any_change_flag, .any_change_irq_enable);

//--- tb/pced_pins.sv
`timescale 1ns/1ps
module pced_pins (
  input wire logic hclk, // Clock.
  output logic [7:0] portc_pin, // Port C pins.
  output logic porte_pin // Port E pin.
);
  initial portc_pin = 8'h00;
  initial porte_pin = 1'b0;
  // Levels move just after an edge, so every change is one clean step.
  task automatic drive(input logic [7:0] c, input logic e);
    @(posedge hclk);
    portc_pin <= c;
    porte_pin <= e;
    repeat (6) @(posedge hclk);
  endtask
endmodule // pced_pins

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, any_change_flag, any_change_irq_enable, porte_pin;
  logic [7:0] portc_pin;
  int error_cnt = 0;
  int compares = 0;
  pced_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .portc_pin, .porte_pin,
    .any_change_flag, .any_change_irq_enable);
  pced_pins pins (.hclk, .portc_pin, .porte_pin);
  initial forever #50 hclk = ~hclk;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    chk("register", e, rd);
  endtask
  task automatic rst();
    hresetn <= 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) rdc(12'(i * 4), 32'h0);
  endtask
  task automatic results();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    rst();
    xfer(1, 12'h000, 32'h0F);
    xfer(1, 12'h004, 32'hF0);
    xfer(1, 12'h00C, 32'hFF);
    xfer(1, 12'h010, 32'hFF);
    xfer(1, 12'h018, 32'hFF);
    rdc(12'h010, 32'h08);
    rdc(12'h018, 32'h08);
    chk("irq_enable", 1, any_change_irq_enable);
    rdc(12'h020, 32'h0);
    pins.drive(8'hFF, 0);
    rdc(12'h008, 32'h0F);
    pins.drive(8'h00, 0);
    rdc(12'h008, 32'hFF);
    chk("any_change_flag", 1, any_change_flag);
    xfer(1, 12'h008, 32'h0F);
    rdc(12'h008, 32'h0F);
    xfer(1, 12'h008, 32'h00);
    rdc(12'h018, 32'h08);
    pins.drive(8'h00, 1);
    rdc(12'h014, 32'h08);
    rdc(12'h018, 32'h09);
    xfer(1, 12'h014, 32'h00);
    rdc(12'h014, 32'h00);
    pins.drive(8'h00, 0);
    rdc(12'h014, 32'h08);
    chk("any_change_flag", 1, any_change_flag);
    rst();
    results();
  end
endmodule // tb
